// >>> design/tlm_pkg.sv
/*
 * constants, register map, field layouts and carrier types for the
 * temperature limit and status monitor.
 * assumes an smbus slave front end that turns bus transactions into
 * single-cycle register read and write strobes.
 */
package tlm_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_MASK1  = 8'h08;
    localparam logic [7:0] ADDR_MASK2  = 8'h09;
    localparam logic [7:0] ADDR_MASK3  = 8'h0A;
    localparam logic [7:0] ADDR_ONTIME = 8'h19;
    localparam logic [7:0] ADDR_STAT1  = 8'h4F;
    localparam logic [7:0] ADDR_STAT2  = 8'h50;
    localparam logic [7:0] ADDR_STAT3  = 8'h51;

    // per channel: 0 local, 1 remote one, 2 remote two
    localparam int         NUM_CH                 = 3;
    localparam logic [7:0] HI_ADDR      [NUM_CH]  = '{8'h0B, 8'h0E, 8'h11};
    localparam logic [7:0] LO_ADDR      [NUM_CH]  = '{8'h0C, 8'h0F, 8'h12};
    localparam logic [7:0] OT_ADDR      [NUM_CH]  = '{8'h0D, 8'h10, 8'h13};
    localparam logic [7:0] VAL_LSB_ADDR [NUM_CH]  = '{8'h40, 8'h42, 8'h44};
    localparam logic [7:0] VAL_MSB_ADDR [NUM_CH]  = '{8'h41, 8'h43, 8'h45};

    // reset values
    localparam logic [7:0] RST_HIGH   = 8'h8B;
    localparam logic [7:0] RST_LOW    = 8'h54;
    localparam logic [7:0] RST_OT     = 8'h95;
    localparam logic [7:0] RST_ONTIME = 8'hFF;
    localparam logic [7:0] RST_CONFIG = 8'h01;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // field positions
    localparam int CFG_RUN_BIT     = 0;
    localparam int CFG_CMP_BIT     = 3;
    localparam int STAT3_ALERT_BIT = 0;

    // status one bit layout per channel
    localparam logic [7:0] HI_BIT  [NUM_CH] = '{8'h80, 8'h20, 8'h04};
    localparam logic [7:0] LO_BIT  [NUM_CH] = '{8'h40, 8'h10, 8'h02};
    localparam logic [7:0] DF_BIT  [NUM_CH] = '{8'h00, 8'h08, 8'h01};
    localparam logic [7:0] CH_MASK [NUM_CH] = '{8'hC0, 8'h38, 8'h07};

    localparam logic [1:0] CH_LOCAL = 2'h0;
    localparam logic [1:0] CH_REM1  = 2'h1;
    localparam logic [1:0] CH_REM2  = 2'h2;
    localparam logic [1:0] CH_LAST  = 2'h2;

    // timing
    localparam int unsigned LOCAL_CONV_MS  = 11;
    localparam int unsigned REMOTE_CONV_MS = 32;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned NS_PER_MS      = 1000000;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tlm_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [1:0]  fault;
    } tlm_adc_t;

    typedef enum logic [0:0] {
        TLM_IDLE,
        TLM_CONV
    } tlm_state_t;

endpackage : tlm_pkg

// >>> design/tlm_monitor.sv
/*
 * limit comparison, sticky status and alert logic for a three channel
 * temperature monitor, with its round-robin conversion sequencer.
 * assumes an smbus slave front end delivering register strobes and an
 * alert response completion pulse, and an adc front end that returns one
 * result per conversion slot; all inputs synchronous to mclk.
 */
// Overview of operation
// - high violation when result is greater than or equal to high limit
// - low violation only when result is strictly below low limit
// - per channel high, low, overtemperature limits reset to 8B, 54, 95
// - overtemperature on-time percentage limit register resets to FF
// - monitoring runs from reset; config bit 0 starts and stops it
// - each channel converted in turn, result stored on completion
// - slot is 11 ms for local, 32 ms for each remote channel
// - after last channel slot, sequence restarts at first channel
// - fan speed measurement runs independently of this sequence
// - each stored result compared against limits, status bit set on violation; overtemperature sets no status bit, only overtemp_signal
// - status 1 means out of limit, registers at 4F to 51
// - set bit holds until condition gone and read or alert response
// - read clears a bit only when its condition has gone
// - status 3 bit 0 shows alert line being pulled low
// - alert pin asserts on any unmasked high, low or diode fault condition, not on overtemperature
// - mask register 1 (08) gates alert sources; masks 2 and 3 gate nothing; masked status still sets
// - status 4F bit layout: local, remote one, remote two high/low
// - bits 3 and 0 of 4F flag remote diode faults
// - config bit 3 selects latched alert (0) or comparator mode (1)
// - comparator mode releases alert when unmasked conditions clear
`timescale 1ns/1ps
module tlm_monitor
    import tlm_pkg::*;
#(
    parameter int unsigned LOCAL_CONV_CYC  = (LOCAL_CONV_MS * NS_PER_MS) / CLK_PERIOD_NS,
    parameter int unsigned REMOTE_CONV_CYC = (REMOTE_CONV_MS * NS_PER_MS) / CLK_PERIOD_NS,
    parameter int unsigned TMR_W           = 20
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire tlm_req_t   host_req,
    output logic [7:0]      host_rdata,
    output logic            host_rvalid,
    input  wire logic       ara_done,
    input  wire tlm_adc_t   adc_in,
    output logic            conv_start,
    output logic [1:0]      conv_ch,
    output logic            alert_out,
    output logic            alert_oe,
    output logic            overtemp_signal
);

    localparam logic [TMR_W-1:0] TMR_ZERO = '0;
    localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);
    localparam logic [TMR_W-1:0] LOC_LAST = TMR_W'(LOCAL_CONV_CYC - 1);
    localparam logic [TMR_W-1:0] REM_LAST = TMR_W'(REMOTE_CONV_CYC - 1);

    logic [7:0]       cfg_reg;
    logic [7:0]       mask_reg    [NUM_CH];
    logic [7:0]       hi_reg      [NUM_CH];
    logic [7:0]       lo_reg      [NUM_CH];
    logic [7:0]       ot_reg      [NUM_CH];
    logic [7:0]       lsb_reg     [NUM_CH];
    logic [7:0]       msb_reg     [NUM_CH];
    logic [7:0]       ontime_reg;
    logic [7:0]       stat1_reg;
    logic [7:0]       cond_reg;
    logic [2:0]       ot_cond_reg;
    logic [7:0]       rdata_reg;
    logic             rvalid_reg;
    logic             alert_reg;
    logic             start_reg;
    tlm_state_t       state_reg;
    tlm_state_t       state_next;
    logic [1:0]       ch_reg;
    logic [1:0]       ch_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic             start_next;

    // conversion sequencer
    function automatic logic [TMR_W-1:0] slot_last(input logic [1:0] ch);
        return (ch == CH_LOCAL) ? LOC_LAST : REM_LAST;
    endfunction : slot_last

    wire        run      = cfg_reg[CFG_RUN_BIT];
    wire        slot_end = (state_reg == TLM_CONV) && (tmr_reg == TMR_ZERO);
    wire [1:0]  ch_wrap  = (ch_reg == CH_LAST) ? CH_LOCAL : ch_reg + CH_REM1;

    // the sequencer takes no input from fan speed logic, so tach runs freely
    always_comb begin
        state_next = state_reg;
        ch_next    = ch_reg;
        tmr_next   = tmr_reg;
        start_next = 1'b0;
        case (state_reg)
            TLM_IDLE: begin
                if (run) begin
                    state_next = TLM_CONV;
                    ch_next    = CH_LOCAL;
                    tmr_next   = slot_last(CH_LOCAL);
                    start_next = 1'b1;
                end
            end
            TLM_CONV: begin
                if (!run) begin
                    state_next = TLM_IDLE;
                    ch_next    = CH_LOCAL;
                    tmr_next   = TMR_ZERO;
                end else if (slot_end) begin
                    ch_next    = ch_wrap;
                    tmr_next   = slot_last(ch_wrap);
                    start_next = 1'b1;
                end else begin
                    tmr_next   = tmr_reg - TMR_ONE;
                end
            end
            default: begin
                state_next = TLM_IDLE;
                ch_next    = CH_LOCAL;
                tmr_next   = TMR_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= TLM_IDLE;
            ch_reg    <= CH_LOCAL;
            tmr_reg   <= TMR_ZERO;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ch_reg    <= ch_next;
            tmr_reg   <= tmr_next;
            start_reg <= start_next;
        end
    end

    // result store and limit comparison
    wire       store   = (state_reg == TLM_CONV) && adc_in.valid && run;
    wire [7:0] res_msb = adc_in.data[15:8];
    wire [7:0] res_lsb = adc_in.data[7:0];
    wire       hi_hit  = res_msb >= hi_reg[ch_reg];
    wire       lo_hit  = res_msb < lo_reg[ch_reg];
    wire       ot_hit  = res_msb >= ot_reg[ch_reg];
    wire       df_hit  = (ch_reg == CH_REM1) ? adc_in.fault[0] :
                         (ch_reg == CH_REM2) ? adc_in.fault[1] : 1'b0;
    wire [7:0] evt_vec = (hi_hit ? HI_BIT[ch_reg] : RST_ZERO) |
                         (lo_hit ? LO_BIT[ch_reg] : RST_ZERO) |
                         (df_hit ? DF_BIT[ch_reg] : RST_ZERO);
    wire [7:0] set_vec   = store ? evt_vec : RST_ZERO;
    wire [7:0] cond_next = store ? ((cond_reg & ~CH_MASK[ch_reg]) | evt_vec) : cond_reg;

    // sticky status; a read or alert response only clears gone conditions
    wire       rd_stat1  = host_req.rd && (host_req.addr == ADDR_STAT1);
    wire [7:0] clr_vec   = (rd_stat1 || ara_done) ? ~cond_reg : RST_ZERO;
    wire [7:0] stat1_next = (stat1_reg & ~clr_vec) | set_vec;

    // alert: latched status in smbus mode, live conditions in comparator mode
    wire [7:0] alert_src  = cfg_reg[CFG_CMP_BIT] ? cond_reg : stat1_reg;
    wire       alert_next = |(alert_src & ~mask_reg[0]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat1_reg   <= RST_ZERO;
            cond_reg    <= RST_ZERO;
            ot_cond_reg <= '0;
            alert_reg   <= 1'b0;
        end else begin
            stat1_reg <= stat1_next;
            cond_reg  <= cond_next;
            alert_reg <= alert_next;
            if (store) begin
                ot_cond_reg[ch_reg] <= ot_hit;
            end
        end
    end

    // register writes and stored results
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_reg    <= RST_CONFIG;
            ontime_reg <= RST_ONTIME;
            for (int c = 0; c < NUM_CH; c++) begin
                mask_reg[c] <= RST_MASK;
                hi_reg[c]   <= RST_HIGH;
                lo_reg[c]   <= RST_LOW;
                ot_reg[c]   <= RST_OT;
                lsb_reg[c]  <= RST_ZERO;
                msb_reg[c]  <= RST_ZERO;
            end
        end else begin
            if (host_req.wr) begin
                if (host_req.addr == ADDR_CONFIG) cfg_reg <= host_req.wdata;
                if (host_req.addr == ADDR_MASK1) mask_reg[0] <= host_req.wdata;
                if (host_req.addr == ADDR_MASK2) mask_reg[1] <= host_req.wdata;
                if (host_req.addr == ADDR_MASK3) mask_reg[2] <= host_req.wdata;
                if (host_req.addr == ADDR_ONTIME) ontime_reg <= host_req.wdata;
                for (int c = 0; c < NUM_CH; c++) begin
                    if (host_req.addr == HI_ADDR[c]) hi_reg[c] <= host_req.wdata;
                    if (host_req.addr == LO_ADDR[c]) lo_reg[c] <= host_req.wdata;
                    if (host_req.addr == OT_ADDR[c]) ot_reg[c] <= host_req.wdata;
                end
            end
            if (store) begin
                lsb_reg[ch_reg] <= res_lsb;
                msb_reg[ch_reg] <= res_msb;
            end
        end
    end

    // read selection; unmapped and reserved locations read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        logic [7:0] v;
        v = RST_ZERO;
        if (a == ADDR_CONFIG) v = cfg_reg;
        if (a == ADDR_MASK1) v = mask_reg[0];
        if (a == ADDR_MASK2) v = mask_reg[1];
        if (a == ADDR_MASK3) v = mask_reg[2];
        if (a == ADDR_ONTIME) v = ontime_reg;
        if (a == ADDR_STAT1) v = stat1_reg;
        if (a == ADDR_STAT3) v[STAT3_ALERT_BIT] = alert_reg;
        for (int c = 0; c < NUM_CH; c++) begin
            if (a == HI_ADDR[c]) v = hi_reg[c];
            if (a == LO_ADDR[c]) v = lo_reg[c];
            if (a == OT_ADDR[c]) v = ot_reg[c];
            if (a == VAL_LSB_ADDR[c]) v = lsb_reg[c];
            if (a == VAL_MSB_ADDR[c]) v = msb_reg[c];
        end
        return v;
    endfunction : read_mux

    logic [7:0] rd_sel;

    // a continuous assignment would not see registers read inside the function
    always_comb begin
        rd_sel = read_mux(host_req.addr);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg  <= RST_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= host_req.rd;
            if (host_req.rd) begin
                rdata_reg <= rd_sel;
            end
        end
    end

    assign host_rdata      = rdata_reg;
    assign host_rvalid     = rvalid_reg;
    assign conv_start      = start_reg;
    assign conv_ch         = ch_reg;
    // open drain: the line only ever gets pulled low
    assign alert_out       = 1'b0;
    assign alert_oe        = alert_reg;
    assign overtemp_signal = |ot_cond_reg;

    a_high_ge: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_LOCAL) && (res_msb >= hi_reg[0]) |=> stat1_reg[7])
        else $error("local high violation not flagged");

    a_low_strict: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_REM1)
        |=> cond_reg[4] == ($past(res_msb) < $past(lo_reg[1])))
        else $error("remote one low compare is not strict less-than");

    a_monitor_stop: assert property (@(posedge mclk) disable iff (rst)
        !run |=> (state_reg == TLM_IDLE) && !conv_start)
        else $error("sequencer kept running with monitor disabled");

    a_slot_wrap: assert property (@(posedge mclk) disable iff (rst)
        slot_end && run && (ch_reg == CH_LAST)
        |=> (ch_reg == CH_LOCAL) && conv_start && (tmr_reg == LOC_LAST))
        else $error("round robin did not restart at local channel");

    a_sticky_hold: assert property (@(posedge mclk) disable iff (rst)
        !(rd_stat1 || ara_done) |=> ($past(stat1_reg) & ~stat1_reg) == RST_ZERO)
        else $error("status bit dropped without read or alert response");

    a_read_keeps: assert property (@(posedge mclk) disable iff (rst)
        rd_stat1 |=> (($past(stat1_reg) & $past(cond_reg)) & ~stat1_reg) == RST_ZERO)
        else $error("read cleared a bit whose condition persists");

    a_set_wins: assert property (@(posedge mclk) disable iff (rst)
        store && (rd_stat1 || ara_done) |=> ($past(set_vec) & ~stat1_reg) == RST_ZERO)
        else $error("new violation lost to clearing read");

    a_alert_flag: assert property (@(posedge mclk) disable iff (rst)
        host_req.rd && (host_req.addr == ADDR_STAT3)
        |=> host_rvalid && (host_rdata[STAT3_ALERT_BIT] == $past(alert_oe)))
        else $error("status 3 alert bit does not follow alert line");

    a_alert_smbus: assert property (@(posedge mclk) disable iff (rst)
        !cfg_reg[CFG_CMP_BIT] && |(stat1_reg & ~mask_reg[0]) |=> alert_oe)
        else $error("alert not asserted for unmasked latched status");

    a_mask_gate: assert property (@(posedge mclk) disable iff (rst)
        !cfg_reg[CFG_CMP_BIT] && ((stat1_reg & ~mask_reg[0]) == RST_ZERO) |=> !alert_oe)
        else $error("masked source drove the alert line");

    a_comp_release: assert property (@(posedge mclk) disable iff (rst)
        cfg_reg[CFG_CMP_BIT] && ((cond_reg & ~mask_reg[0]) == RST_ZERO) |=> !alert_oe)
        else $error("comparator mode alert not released");

    a_res_store: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_REM2)
        |=> (msb_reg[2] == $past(res_msb)) && (lsb_reg[2] == $past(res_lsb)))
        else $error("remote two result not stored");

    a_local_slot: assert property (@(posedge mclk) disable iff (rst)
        conv_start && (conv_ch == CH_LOCAL) |-> tmr_reg == LOC_LAST)
        else $error("local slot length wrong");

    a_remote_slot: assert property (@(posedge mclk) disable iff (rst)
        conv_start && (conv_ch != CH_LOCAL) |-> tmr_reg == REM_LAST)
        else $error("remote slot length wrong");

    a_high_miss: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_REM2) && !(res_msb >= hi_reg[2]) |=> !cond_reg[2])
        else $error("remote two high flagged below limit");

    a_status_set: assert property (@(posedge mclk) disable iff (rst)
        store |=> (stat1_reg & $past(evt_vec)) == $past(evt_vec))
        else $error("violation did not set status");

    a_diode_one: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_REM1) && adc_in.fault[0] |=> stat1_reg[3])
        else $error("remote one diode fault not flagged");

    a_diode_two: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_REM2) && adc_in.fault[1] |=> stat1_reg[0])
        else $error("remote two diode fault not flagged");

    a_local_bits: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_LOCAL)
        |=> (cond_reg & ~CH_MASK[0]) == $past(cond_reg & ~CH_MASK[0]))
        else $error("local result touched remote status bits");

    a_ot_pin: assert property (@(posedge mclk) disable iff (rst)
        store && (ch_reg == CH_LOCAL) && (res_msb >= ot_reg[0]) |=> overtemp_signal)
        else $error("overtemperature output not raised");

    a_limit_write: assert property (@(posedge mclk) disable iff (rst)
        host_req.wr && (host_req.addr == HI_ADDR[1]) |=> hi_reg[1] == $past(host_req.wdata))
        else $error("remote one high limit write lost");

    a_read_stat1: assert property (@(posedge mclk) disable iff (rst)
        rd_stat1 |=> host_rdata == $past(stat1_reg))
        else $error("status one read returned wrong value");

    a_comp_alert: assert property (@(posedge mclk) disable iff (rst)
        cfg_reg[CFG_CMP_BIT] && |(cond_reg & ~mask_reg[0]) |=> alert_oe)
        else $error("comparator mode alert not asserted");

    a_rvalid_follow: assert property (@(posedge mclk) disable iff (rst)
        host_rvalid == $past(host_req.rd))
        else $error("read valid does not follow read strobe");

    a_run_start: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == TLM_IDLE) && run
        |=> conv_start && (ch_reg == CH_LOCAL) && (state_reg == TLM_CONV))
        else $error("monitor did not start at local channel");

    a_ch_advance: assert property (@(posedge mclk) disable iff (rst)
        slot_end && run && (ch_reg == CH_LOCAL)
        |=> (ch_reg == CH_REM1) && conv_start && (tmr_reg == REM_LAST))
        else $error("sequence did not move to remote one");

    a_clear_gone: assert property (@(posedge mclk) disable iff (rst)
        rd_stat1 && !store |=> (stat1_reg & ~$past(cond_reg)) == RST_ZERO)
        else $error("read left a bit whose condition is gone");

endmodule : tlm_monitor

// >>> sim/tlm_host_model.sv
/*
 * host side model: register writes and reads as one-cycle strobes.
 * assumes the monitor answers a read exactly one cycle after the read edge.
 */
`timescale 1ns/1ps
module tlm_host_model
    import tlm_pkg::*;
(
    input  wire logic       mclk,
    output tlm_req_t        host_req,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_rvalid
);
    initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // released bus shows inverted values so a stale request cannot pass for a live one
    task automatic idle_bus;
        host_req.wr    <= 1'b0;
        host_req.rd    <= 1'b0;
        host_req.addr  <= ~host_req.addr;
        host_req.wdata <= ~host_req.wdata;
    endtask : idle_bus

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        idle_bus();
    endtask : reg_wr

    // status is learnt only by reading it back, never from the alert line alone
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: host_req.wdata};
        @(posedge mclk);
        idle_bus();
        #1;
        d = (host_rvalid === 1'b1) ? host_rdata : 8'hXX;
    endtask : reg_rd
endmodule : tlm_host_model

// >>> sim/tlm_monitor_tb_top.sv
/*
 * self-checking bench for the limit and status monitor, with an adc driver.
 * assumes short conversion slots set by parameter; expectations from a model.
 */
`timescale 1ns/1ps
module tlm_monitor_tb_top
    import tlm_pkg::*;
;
    localparam int LC = 8;
    localparam int RC = 12;
    logic       mclk, rst, ara_done;
    logic       pend = 1'b0;
    tlm_req_t   host_req;
    tlm_adc_t   adc_in = '{valid: 1'b0, data: 16'h0000, fault: 2'b00};
    logic [7:0] host_rdata, mdl_stat, mask_m, nl;
    logic       host_rvalid, conv_start, alert_out, alert_oe, overtemp_signal;
    logic [1:0] conv_ch, flt_m;
    logic [7:0] hi_m [3], lo_m [3], ot_m [3], val_m [3], lsb_m [3];
    int         bad_count, cmp_count, seed, k, ch, mode;
    int         cyc = 0;

    tlm_monitor #(.LOCAL_CONV_CYC(LC), .REMOTE_CONV_CYC(RC)) u_tlm_monitor (
        .mclk(mclk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .ara_done(ara_done), .adc_in(adc_in),
        .conv_start(conv_start), .conv_ch(conv_ch), .alert_out(alert_out),
        .alert_oe(alert_oe), .overtemp_signal(overtemp_signal));
    tlm_host_model u_tlm_host_model (.mclk(mclk), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // adc answers once per slot, two cycles after the slot opens
    always @(posedge mclk) begin
        pend <= conv_start;
        if (pend) begin
            nl = 8'($random(seed));
            lsb_m[conv_ch] <= nl;
            adc_in <= '{valid: 1'b1, data: {val_m[conv_ch], nl}, fault: flt_m};
        end else begin
            adc_in <= '{valid: 1'b0, data: ~adc_in.data, fault: ~adc_in.fault};
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    function automatic logic [7:0] cond_all();
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < NUM_CH; i++) begin
            if (val_m[i] >= hi_m[i]) c |= HI_BIT[i];
            if (val_m[i] < lo_m[i]) c |= LO_BIT[i];
            if (i > 0 && flt_m[i-1]) c |= DF_BIT[i];
        end
        return c;
    endfunction : cond_all

    function automatic logic ot_any();
        ot_any = 1'b0;
        for (int i = 0; i < NUM_CH; i++) ot_any |= (val_m[i] >= ot_m[i]);
    endfunction : ot_any

    task automatic results;
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({7'h00, got}, {7'h00, exp});
    endtask : chk_pin

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_tlm_host_model.reg_wr(a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_tlm_host_model.reg_rd(a, d);
        chk_reg(d, exp);
    endtask : rd_chk

    task automatic next_start(output int c, output int g);
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (conv_start !== 1'b1 && g < 100);
        c = conv_ch;
    endtask : next_start

    // waits a whole pass so every channel has been compared with stable inputs
    task automatic settle_check(input logic use_ara);
        logic al;
        repeat (40) @(posedge mclk);
        mdl_stat |= cond_all();
        if (use_ara) begin
            // meet a fresh result so that set and clear land on one edge
            do @(posedge mclk); while (pend !== 1'b1);
            ara_done <= 1'b1;
            @(posedge mclk);
            ara_done <= 1'b0;
            mdl_stat = cond_all();
        end
        rd_chk(ADDR_STAT1, mdl_stat);
        mdl_stat = cond_all();
        repeat (3) @(posedge mclk);
        al = |((mode != 0 ? cond_all() : mdl_stat) & ~mask_m);
        chk_pin(alert_oe, al);
        chk_pin(alert_out, 1'b0);
        chk_pin(overtemp_signal, ot_any());
        rd_chk(ADDR_STAT3, {7'h00, al});
        rd_chk(ADDR_STAT1, mdl_stat);
    endtask : settle_check

    initial begin
        seed = 89037;
        bad_count = 0;
        cmp_count = 0;
        mode = 0;
        rst = 1'b1;
        ara_done = 1'b0;
        flt_m = 2'b00;
        mask_m = 8'h00;
        mdl_stat = 8'h00;
        for (k = 0; k < NUM_CH; k++) begin
            hi_m[k] = RST_HIGH;
            lo_m[k] = RST_LOW;
            ot_m[k] = RST_OT;
            val_m[k] = 8'h60;
        end
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (k = 0; k < NUM_CH; k++) begin
            rd_chk(HI_ADDR[k], RST_HIGH);
            rd_chk(LO_ADDR[k], RST_LOW);
            rd_chk(OT_ADDR[k], RST_OT);
        end
        rd_chk(ADDR_ONTIME, RST_ONTIME);
        rd_chk(ADDR_CONFIG, RST_CONFIG);
        wr(8'h7E, 8'hA5);
        rd_chk(8'h7E, 8'h00);
        rd_chk(ADDR_STAT2, 8'h00);
        next_start(ch, k);
        while (ch != 0) next_start(ch, k);
        for (int i = 0; i < 3; i++) begin
            next_start(ch, k);
            chk_reg(8'(ch), 8'((i + 1) % 3));
            chk_reg(8'(k), 8'(i == 0 ? LC : RC));
        end
        wr(ADDR_CONFIG, 8'h00);
        next_start(ch, k);
        chk_reg(8'(k), 8'h64);
        for (k = 0; k < NUM_CH; k++) begin
            rd_chk(VAL_MSB_ADDR[k], val_m[k]);
            rd_chk(VAL_LSB_ADDR[k], lsb_m[k]);
        end
        wr(ADDR_CONFIG, RST_CONFIG);
        next_start(ch, k);
        chk_reg(8'(ch), 8'h00);
        for (mode = 0; mode < 2; mode++) begin
            wr(ADDR_CONFIG, mode != 0 ? 8'h09 : 8'h01);
            for (k = 0; k < NUM_CH; k++) begin
                hi_m[k] = 8'h80 | 8'($random(seed) & 63);
                lo_m[k] = 8'h20 | 8'($random(seed) & 63);
                ot_m[k] = 8'h80 | 8'($random(seed) & 63);
                wr(HI_ADDR[k], hi_m[k]);
                wr(LO_ADDR[k], lo_m[k]);
                wr(OT_ADDR[k], ot_m[k]);
            end
            settle_check(1'b0);
            for (int c = 0; c < 6; c++) begin
                mask_m = 8'($random(seed));
                flt_m <= 2'($random(seed));
                wr(ADDR_MASK1, mask_m);
                for (k = 0; k < NUM_CH; k++) begin
                    case ((c + k) % 4)
                        0: val_m[k] <= hi_m[k];
                        1: val_m[k] <= hi_m[k] - 8'h01;
                        2: val_m[k] <= lo_m[k];
                        default: val_m[k] <= lo_m[k] - 8'h01;
                    endcase
                end
                settle_check(1'($random(seed)));
            end
        end
        results();
    end
endmodule : tlm_monitor_tb_top
